// ==== common/psc_pkg.sv ====
// shared constants and types for the strap loader and mac pin block
package psc_pkg;
    // pin slots of the shared strap / output pins
    localparam int PIN_ADDR0 = 0;
    localparam int PIN_ADDR1 = 1;
    localparam int PIN_ADDR2 = 2;
    localparam int PIN_ADDR3 = 3;
    localparam int PIN_ADDR4 = 4;
    localparam int PIN_HW_SPEED = 5;
    localparam int PIN_REG_ACCESS = 6;
    localparam int PIN_CROSSOVER = 7;
    localparam int PIN_RX_ISOLATE = 8;
    localparam int PIN_SERIAL = 9;
    localparam int PIN_DUPLEX = 10;
    localparam int PIN_RMII = 11;
    localparam int PIN_AUTONEG = 12;
    localparam int PIN_STATION = 13;
    localparam int PIN_SPEED = 14;
    localparam int NUM_PINS = 15;
    localparam logic [NUM_PINS-1:0] PINS_RELEASED = {NUM_PINS{1'b1}};
    // strap sampling window after reset release
    localparam int SYS_CLK_MHZ = 20;
    localparam int STRAP_HOLD_NS = 200;
    localparam int STRAP_CYCLES = (STRAP_HOLD_NS * SYS_CLK_MHZ + 999) / 1000;
    localparam int STRAP_CNT_W = 4;
    // register map, byte addresses
    localparam int REG_ADDR_W = 4;
    localparam logic [REG_ADDR_W-1:0] REG_STRAPS = 4'h0;
    localparam logic [REG_ADDR_W-1:0] REG_CONTROL = 4'h4;
    localparam logic [REG_ADDR_W-1:0] REG_STATUS = 4'h8;
    localparam int CTRL_RX_ENABLE = 0;
    localparam int CTRL_LED_OFF = 1;
    localparam logic [1:0] CTRL_RESET = 2'h1;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // interface mode strap patterns
    localparam logic [1:0] MODE_PAT_SERIAL = 2'h1;
    localparam logic [1:0] MODE_PAT_MII = 2'h0;
    localparam int RX_FIFO_DEPTH = 8;
    localparam int NIBBLE_W = 4;

    typedef enum logic [1:0] {MODE_MII, MODE_SERIAL, MODE_RMII} psc_mode_type;
    typedef enum logic [1:0] {REG_SEL_STRAPS, REG_SEL_CONTROL, REG_SEL_STATUS,
        REG_SEL_NONE} psc_reg_sel_type;

    typedef struct packed {
        logic station_or_repeater;
        logic crossover_auto;
        logic rx_isolate;
        logic full_reg_access;
        logic hw_speed_ctl;
        logic autoneg;
        logic speed_100;
        logic full_duplex;
        logic [1:0] if_mode;
        logic [4:0] phy_addr;
    } psc_strap_type;
endpackage : psc_pkg

// ==== hw/psc_strap_cfg.sv ====
// strap latching, mac pin muxing, receive fifo and axi4-lite registers
// Contract
// - Shared pins are inputs during reset, outputs once reset ends; here the mii-only pins stay inputs in rmii.
// - Five-bit phy address comes from address straps latched at reset.
// - Address bit four always latches as one.
// - Mode strap: 1x selects rmii, 01 serial, 00 mii.
// - Duplex strap: one full, zero half; ignored under auto-negotiation.
// - Speed strap: one 100M, zero 10M; ignored under auto-negotiation.
// - Auto-negotiation strap enables when one, disables when zero.
// - Hardware speed control and full register access straps latch at reset.
// - Isolate strap makes address-one pin a live isolate input, led off.
// - Mii receive nibble follows rx clock, valid only with rx valid.
// - Rmii sends two bits each reference period with carrier/valid.
// - Mii transmit nibble sampled on tx clock, ignored without tx enable.
// - Rmii takes two transmit bits per reference period with tx enable.
// - In mii the speed strap pin outputs tx clock; bits 2,3 mii only.
// - Indicators default to activity on first, speed on second.
//
// Chosen here: the address map and the AXI4-Lite slave port.

module psc_fifo #(
    parameter int WIDTH = 4,
    parameter int DEPTH = 8
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    output logic [$clog2(DEPTH+1)-1:0] count
);
    localparam int PTR_W = $clog2(DEPTH);
    localparam int CNT_W = $clog2(DEPTH+1);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PTR_W-1:0] wr_ptr_q;
    logic [PTR_W-1:0] rd_ptr_q;
    logic [CNT_W-1:0] count_q;
    logic push;
    logic pop;

    assign in_ready = (count_q != CNT_W'(DEPTH));
    assign out_valid = (count_q != '0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem_q[rd_ptr_q];
    assign count = count_q;

    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem_q[wr_ptr_q] <= in_data;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q <= '0;
        end else begin
            if (push) begin
                wr_ptr_q <= (wr_ptr_q == PTR_W'(DEPTH-1)) ? '0 : wr_ptr_q + 1'b1;
            end
            if (pop) begin
                rd_ptr_q <= (rd_ptr_q == PTR_W'(DEPTH-1)) ? '0 : rd_ptr_q + 1'b1;
            end
            count_q <= count_q + CNT_W'(push) - CNT_W'(pop);
        end
    end
endmodule : psc_fifo

module psc_strap_cfg
    import psc_pkg::*;
#(
    parameter int FIFO_DEPTH = RX_FIFO_DEPTH
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic hw_reset_pin_n,
    input wire logic ref_clk_pin,
    input wire logic [NUM_PINS-1:0] strap_pin_in,
    output logic [NUM_PINS-1:0] strap_pin_out,
    output logic [NUM_PINS-1:0] strap_pin_oe_n,
    input wire logic tx_en_pin,
    input wire logic [NIBBLE_W-1:0] txd_pin,
    output logic [NIBBLE_W-1:0] line_tx_data,
    output logic line_tx_valid,
    input wire logic line_rx_valid,
    output logic line_rx_ready,
    input wire logic [NIBBLE_W-1:0] line_rx_data,
    input wire logic line_speed_100,
    input wire logic line_full_duplex,
    input wire logic [REG_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [REG_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    typedef enum logic {ST_STRAP, ST_RUN} psc_phase_type;
    localparam int SYNC_W = NUM_PINS + NIBBLE_W + 3;
    localparam int FCNT_W = $clog2(FIFO_DEPTH+1);

    function automatic psc_mode_type mode_of(input logic [1:0] pat);
        if (pat[1]) begin
            mode_of = MODE_RMII;
        end else if (pat == MODE_PAT_SERIAL) begin
            mode_of = MODE_SERIAL;
        end else begin
            mode_of = MODE_MII;
        end
    endfunction : mode_of

    function automatic psc_reg_sel_type reg_sel(input logic [REG_ADDR_W-1:0] addr);
        case (addr)
            REG_STRAPS: reg_sel = REG_SEL_STRAPS;
            REG_CONTROL: reg_sel = REG_SEL_CONTROL;
            REG_STATUS: reg_sel = REG_SEL_STATUS;
            default: reg_sel = REG_SEL_NONE;
        endcase
    endfunction : reg_sel

    logic [SYNC_W-1:0] sync1_q;
    logic [SYNC_W-1:0] sync2_q;
    logic ref_prev_q;
    logic hw_rst_s_n;
    logic ref_s;
    logic tx_en_s;
    logic [NIBBLE_W-1:0] txd_s;
    logic [NUM_PINS-1:0] pin_s;
    logic ref_rise;
    logic ref_fall;
    psc_phase_type phase_q;
    logic [STRAP_CNT_W-1:0] strap_cnt_q;
    psc_strap_type straps_q;
    psc_strap_type strap_d;
    psc_mode_type mode;
    logic is_mii;
    logic speed_100;
    logic full_duplex;
    logic iso_active;
    logic [1:0] ctrl_q;
    logic [NUM_PINS-1:0] pin_out_d;
    logic [NUM_PINS-1:0] pin_oe_n_d;
    logic [NUM_PINS-1:0] pin_out_q;
    logic [NUM_PINS-1:0] pin_oe_n_q;
    logic [NIBBLE_W-1:0] rxd_q;
    logic rxdv_q;
    logic fifo_valid;
    logic fifo_pop;
    logic [NIBBLE_W-1:0] fifo_data;
    logic [FCNT_W-1:0] fifo_count;
    logic [NIBBLE_W-1:0] tx_data_q;
    logic tx_valid_q;
    logic aw_hold_q;
    logic w_hold_q;
    logic [REG_ADDR_W-1:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;

    // every pin input (reset, reference clock, transmit and strap pins) crosses on two flops before use
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_q <= '0;
            sync2_q <= '0;
            ref_prev_q <= 1'b0;
        end else begin
            sync1_q <= {hw_reset_pin_n, ref_clk_pin, tx_en_pin, txd_pin, strap_pin_in};
            sync2_q <= sync1_q;
            ref_prev_q <= ref_s;
        end
    end
    assign {hw_rst_s_n, ref_s, tx_en_s, txd_s, pin_s} = sync2_q;
    assign ref_rise = ref_s && !ref_prev_q;
    assign ref_fall = !ref_s && ref_prev_q;

    // strap image as seen on the pins right now
    always_comb begin
        strap_d.phy_addr = pin_s[PIN_ADDR4:PIN_ADDR0];
        strap_d.phy_addr[4] = 1'b1;
        strap_d.if_mode = {pin_s[PIN_RMII], pin_s[PIN_SERIAL]};
        strap_d.full_duplex = pin_s[PIN_DUPLEX];
        strap_d.speed_100 = pin_s[PIN_SPEED];
        strap_d.autoneg = pin_s[PIN_AUTONEG];
        strap_d.hw_speed_ctl = pin_s[PIN_HW_SPEED];
        strap_d.full_reg_access = pin_s[PIN_REG_ACCESS];
        strap_d.rx_isolate = pin_s[PIN_RX_ISOLATE];
        strap_d.crossover_auto = pin_s[PIN_CROSSOVER];
        strap_d.station_or_repeater = pin_s[PIN_STATION];
    end

    // sample window runs while the reset pin is low and a little after
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_q <= ST_STRAP;
            strap_cnt_q <= '0;
        end else begin
            case (phase_q)
                ST_STRAP: begin
                    if (!hw_rst_s_n) begin
                        strap_cnt_q <= '0;
                    end else if (strap_cnt_q == STRAP_CNT_W'(STRAP_CYCLES - 1)) begin
                        phase_q <= ST_RUN;
                    end else begin
                        strap_cnt_q <= strap_cnt_q + 1'b1;
                    end
                end
                ST_RUN: begin
                    if (!hw_rst_s_n) begin
                        phase_q <= ST_STRAP;
                        strap_cnt_q <= '0;
                    end
                end
                default: phase_q <= ST_STRAP;
            endcase
        end
    end

    // latch every strap; frozen outside the window
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            straps_q <= '0;
        end else if (phase_q == ST_STRAP) begin
            straps_q <= strap_d;
        end
    end

    assign mode = mode_of(straps_q.if_mode);
    assign is_mii = (mode != MODE_RMII);
    // straps only count with auto-negotiation off
    assign speed_100 = straps_q.autoneg ? line_speed_100 : straps_q.speed_100;
    assign full_duplex = straps_q.autoneg ? line_full_duplex : straps_q.full_duplex;
    // live isolate input read only when the strap asked for it
    assign iso_active = straps_q.rx_isolate && pin_s[PIN_ADDR1];

    psc_fifo #(
        .WIDTH(NIBBLE_W),
        .DEPTH(FIFO_DEPTH)
    ) u_rx_fifo (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .in_valid(line_rx_valid),
        .in_ready(line_rx_ready),
        .in_data(line_rx_data),
        .out_valid(fifo_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_data),
        .count(fifo_count)
    );

    // one item per reference rise; fifo stalls otherwise
    assign fifo_pop = ref_rise && fifo_valid && ctrl_q[CTRL_RX_ENABLE] && (phase_q == ST_RUN);

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rxd_q <= '0;
            rxdv_q <= 1'b0;
        end else if (phase_q == ST_STRAP) begin
            rxd_q <= '0;
            rxdv_q <= 1'b0;
        end else if (ref_rise) begin
            // data zeroed whenever valid is low
            rxd_q <= fifo_pop ? (is_mii ? fifo_data : {2'h0, fifo_data[1:0]}) : '0;
            rxdv_q <= fifo_pop;
        end
    end

    // sampled on the falling edge: the mac changes data after the rising one
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_data_q <= '0;
            tx_valid_q <= 1'b0;
        end else begin
            // taken only while tx enable is high
            tx_valid_q <= ref_fall && tx_en_s && (phase_q == ST_RUN);
            if (ref_fall && tx_en_s) begin
                // upper bits used in mii only
                tx_data_q <= is_mii ? txd_s : {2'h0, txd_s[1:0]};
            end
        end
    end
    assign line_tx_data = tx_data_q;
    assign line_tx_valid = tx_valid_q;

    always_comb begin
        pin_out_d = '0;
        pin_oe_n_d = PINS_RELEASED;
        if (phase_q == ST_RUN) begin
            // activity on the first indicator, speed on the second
            pin_out_d[PIN_ADDR0] = (rxdv_q || tx_en_s) && !ctrl_q[CTRL_LED_OFF];
            pin_out_d[PIN_ADDR1] = speed_100 && !ctrl_q[CTRL_LED_OFF];
            pin_out_d[PIN_ADDR2] = 1'b1;
            pin_out_d[PIN_RX_ISOLATE] = rxd_q[1];
            pin_out_d[PIN_DUPLEX] = rxd_q[0];
            pin_out_d[PIN_RMII] = rxdv_q;
            pin_oe_n_d[PIN_ADDR0] = 1'b0;
            // led dropped when the pin serves as isolate input
            pin_oe_n_d[PIN_ADDR1] = straps_q.rx_isolate;
            pin_oe_n_d[PIN_ADDR2] = 1'b0;
            pin_oe_n_d[PIN_ADDR4] = 1'b0;
            pin_oe_n_d[PIN_SERIAL] = 1'b0;
            pin_oe_n_d[PIN_RX_ISOLATE] = iso_active;
            pin_oe_n_d[PIN_DUPLEX] = iso_active;
            pin_oe_n_d[PIN_RMII] = iso_active;
            if (is_mii) begin
                pin_out_d[PIN_ADDR3] = rxd_q[2];
                pin_out_d[PIN_CROSSOVER] = rxd_q[3];
                pin_out_d[PIN_AUTONEG] = ref_s;
                pin_out_d[PIN_HW_SPEED] = rxdv_q || tx_en_s;
                pin_out_d[PIN_REG_ACCESS] = rxdv_q && tx_en_s && !full_duplex;
                // transmit clock out on the speed strap pin
                pin_out_d[PIN_SPEED] = ref_s;
                pin_oe_n_d[PIN_ADDR3] = iso_active;
                pin_oe_n_d[PIN_CROSSOVER] = iso_active;
                pin_oe_n_d[PIN_AUTONEG] = iso_active;
                pin_oe_n_d[PIN_STATION] = iso_active;
                pin_oe_n_d[PIN_HW_SPEED] = 1'b0;
                pin_oe_n_d[PIN_REG_ACCESS] = 1'b0;
                pin_oe_n_d[PIN_SPEED] = 1'b0;
            end
        end
    end

    // pins released in reset, driven after
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_out_q <= '0;
            pin_oe_n_q <= PINS_RELEASED;
        end else begin
            pin_out_q <= pin_out_d;
            pin_oe_n_q <= pin_oe_n_d;
        end
    end
    assign strap_pin_out = pin_out_q;
    assign strap_pin_oe_n = pin_oe_n_q;

    // axi4-lite write: address and data held independently
    assign s_axi_awready = !aw_hold_q && !bvalid_q;
    assign s_axi_wready = !w_hold_q && !bvalid_q;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            aw_addr_q <= '0;
            w_data_q <= '0;
            w_strb_q <= '0;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
            ctrl_q <= CTRL_RESET;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (aw_hold_q && w_hold_q && !bvalid_q) begin
                aw_hold_q <= 1'b0;
                w_hold_q <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= RESP_OKAY;
                case (reg_sel(aw_addr_q))
                    REG_SEL_CONTROL: begin
                        if (w_strb_q[0]) begin
                            ctrl_q <= w_data_q[1:0];
                        end
                    end
                    REG_SEL_STRAPS, REG_SEL_STATUS: bresp_q <= RESP_OKAY;
                    default: bresp_q <= RESP_SLVERR;
                endcase
            end else if (bvalid_q && s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;

    // axi4-lite read: one beat, answer the cycle after the address
    assign s_axi_arready = !rvalid_q;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_q <= 1'b1;
            rresp_q <= RESP_OKAY;
            case (reg_sel(s_axi_araddr))
                // latched control straps visible to software
                REG_SEL_STRAPS: rdata_q <= 32'(straps_q);
                REG_SEL_CONTROL: rdata_q <= 32'(ctrl_q);
                REG_SEL_STATUS: rdata_q <= 32'({fifo_count, iso_active, mode,
                    full_duplex, speed_100, phase_q == ST_RUN});
                default: begin
                    rdata_q <= '0;
                    rresp_q <= RESP_SLVERR;
                end
            endcase
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    a_pins_released: assert property (@(posedge sys_clk) disable iff (!rst_n)
        phase_q == ST_STRAP && $past(phase_q) == ST_STRAP |-> pin_oe_n_q == PINS_RELEASED)
        else $error("pin driven during strap window");
    a_addr_latched: assert property (@(posedge sys_clk) disable iff (!rst_n)
        phase_q == ST_RUN && $past(phase_q) == ST_STRAP
        |-> straps_q.phy_addr[3:0] == $past(pin_s[PIN_ADDR3:PIN_ADDR0]))
        else $error("phy address not latched from pins");
    a_addr_bit_four: assert property (@(posedge sys_clk) disable iff (!rst_n)
        phase_q == ST_RUN |-> straps_q.phy_addr[4])
        else $error("address bit four not one");
    a_mode_rmii: assert property (@(posedge sys_clk) disable iff (!rst_n)
        phase_q == ST_RUN && straps_q.if_mode[1] |=> pin_oe_n_q[PIN_SPEED])
        else $error("tx clock driven in rmii mode");
    a_duplex_forced: assert property (@(posedge sys_clk) disable iff (!rst_n)
        phase_q == ST_RUN && !straps_q.autoneg && rxdv_q && tx_en_s && is_mii
        |=> pin_out_q[PIN_REG_ACCESS] == !$past(straps_q.full_duplex))
        else $error("collision ignores duplex strap");
    a_speed_led: assert property (@(posedge sys_clk) disable iff (!rst_n)
        phase_q == ST_RUN && !straps_q.autoneg && !ctrl_q[CTRL_LED_OFF]
        ##1 phase_q == ST_RUN |-> pin_out_q[PIN_ADDR1] == $past(straps_q.speed_100))
        else $error("speed indicator ignores speed strap");
    a_isolate_rx: assert property (@(posedge sys_clk) disable iff (!rst_n)
        phase_q == ST_RUN && iso_active |=> pin_oe_n_q[PIN_DUPLEX] && pin_oe_n_q[PIN_RMII])
        else $error("receive pins driven while isolated");
    a_rx_data_quiet: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !rxdv_q |-> rxd_q == '0)
        else $error("receive data present without valid");
    a_tx_ignored: assert property (@(posedge sys_clk) disable iff (!rst_n)
        tx_valid_q |-> $past(tx_en_s) && $past(ref_fall))
        else $error("transmit data taken without enable");
    a_straps_frozen: assert property (@(posedge sys_clk) disable iff (!rst_n)
        phase_q == ST_RUN && $past(phase_q) == ST_RUN |-> $stable(straps_q))
        else $error("latched straps changed after reset");
endmodule : psc_strap_cfg

// ==== dv/psc_mac_model.sv ====
// mac and board strap model facing the strap loader pins
module psc_mac_model (
    input wire logic tx_go,
    input wire logic [14:0] strap_val,
    input wire logic [14:0] pin_out,
    input wire logic [14:0] pin_oe_n,
    output logic ref_clk,
    output logic tx_en,
    output logic [3:0] txd,
    output logic [14:0] pin_in
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        ref_clk = 1'b0;
        tx_en = 1'b0;
        txd = 4'h0;
    end
    always #200 ref_clk = ~ref_clk;
    // released pins show the board pulls
    assign pin_in = (pin_oe_n & strap_val) | (~pin_oe_n & pin_out);
    // data changes after rising edge; idle data toggles so it is never reused
    always @(posedge ref_clk) begin
        tx_en <= tx_go;
        txd <= tx_go ? txd + 4'h5 : ~txd;
    end
endmodule : psc_mac_model

// ==== dv/tb.sv ====
// self-checking bench for the strap loader and mac pins
module tb import psc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk = 1'b0, rst_n = 1'b0, hw_reset_pin_n = 1'b1, ref_clk_pin, tx_en_pin;
    logic [NUM_PINS-1:0] strap_pin_in, strap_pin_out, strap_pin_oe_n, sv = 15'h0, old;
    logic [3:0] txd_pin, line_tx_data, line_rx_data = 4'h0, s_axi_wstrb = 4'hf;
    logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
    logic line_tx_valid, line_rx_valid = 1'b0, line_rx_ready, tx_go = 1'b0;
    logic line_speed_100 = 1'b0, line_full_duplex = 1'b0;
    logic s_axi_awvalid = 1'b0, s_axi_awready, s_axi_wvalid = 1'b0, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, seed = 32'h8d4a;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [65:0] rd_q [$];
    logic [3:0] tx_q [$], rx_q [$];
    int num_errors = 0, num_checks = 0;
    psc_strap_cfg u_psc_strap_cfg (.*);
    psc_mac_model u_psc_mac_model (.tx_go(tx_go), .strap_val(sv), .pin_out(strap_pin_out),
        .pin_oe_n(strap_pin_oe_n), .ref_clk(ref_clk_pin), .tx_en(tx_en_pin),
        .txd(txd_pin), .pin_in(strap_pin_in));
    always #25 sys_clk = ~sys_clk;
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    function automatic logic [31:0] xs(input logic [14:0] s);
        return {17'h0, s[13], s[7], s[8], s[6], s[5], s[12], 4'h0, 1'b1, s[3:0]};
    endfunction : xs
    function automatic logic [31:0] xt(input logic [14:0] s);
        logic [1:0] m;
        m = s[11] ? 2'h2 : {1'b0, s[9]};
        return {27'h0, m, s[12] ? line_full_duplex : s[10], s[12] ? line_speed_100 : s[14], 1'b1};
    endfunction : xt
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : report_and_stop
    task automatic hang();
        num_errors++;
        report_and_stop();
    endtask : hang
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
        int n;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge sys_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        if (n == 50) hang();
        chk(32'(s_axi_bresp), 32'(r));
        s_axi_bready <= 1'b0;
    endtask : axi_wr
    // expectation noted here, compared by the read watcher
    task automatic axi_rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e,
                          input logic [1:0] r);
        int n;
        rd_q.push_back({r, m, e});
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge sys_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        if (n == 50) hang();
        s_axi_rready <= 1'b0;
        // one idle edge so a following read never re-raises rready in the same step
        @(posedge sys_clk);
    endtask : axi_rd
    always @(posedge sys_clk) begin
        if (s_axi_rvalid && s_axi_rready && rd_q.size() > 0) begin
            chk(s_axi_rdata & rd_q[0][63:32], rd_q[0][31:0]);
            chk(32'(s_axi_rresp), 32'(rd_q[0][65:64]));
            void'(rd_q.pop_front());
        end
    end
    always @(negedge ref_clk_pin) if (tx_en_pin) tx_q.push_back(txd_pin);
    // each accepted nibble appears once, in order
    always @(posedge sys_clk) begin
        if (line_tx_valid === 1'b1) begin
            chk(32'(line_tx_data), 32'(tx_q.pop_front()));
        end
    end
    // sampled on the next reference rise, a little over half a reference period after the pins change
    always @(posedge ref_clk_pin) if (strap_pin_oe_n[11] === 1'b0 && strap_pin_out[11] === 1'b1)
        chk(32'({strap_pin_out[7], strap_pin_out[3], strap_pin_out[8], strap_pin_out[10]}),
            32'(rx_q.pop_front()));
    initial begin
        repeat (20000) @(posedge sys_clk);
        hang();
    end
    initial begin
        logic [31:0] r;
        int n;
        r = rnd();
        // first run: mii, no isolate, auto-negotiation off so speed and duplex straps count
        sv = r[14:0] & 15'h64ff;
        line_speed_100 = r[16];
        line_full_duplex = r[17];
        repeat (16) @(posedge sys_clk);
        chk(32'(strap_pin_oe_n), 32'(PINS_RELEASED));
        rst_n <= 1'b1;
        repeat (12) @(posedge sys_clk);
        chk(32'(strap_pin_oe_n[11]), 32'h0);
        chk(32'(strap_pin_out[PIN_ADDR1]), 32'(sv[PIN_SPEED]));
        axi_rd(REG_STRAPS, 32'h7e1f, xs(sv), RESP_OKAY);
        axi_rd(REG_STATUS, 32'h1f, xt(sv), RESP_OKAY);
        axi_rd(4'hc, 32'hffffffff, 32'h0, RESP_SLVERR);
        axi_wr(4'hc, 32'h0, RESP_SLVERR);
        $display("straps and registers done");
        tx_go <= 1'b1;
        repeat (80) @(posedge sys_clk);
        tx_go <= 1'b0;
        repeat (40) @(posedge sys_clk);
        chk(32'(tx_q.size()), 32'h0);
        $display("transmit done");
        // receive paused so the fifo fills until it refuses
        axi_wr(REG_CONTROL, 32'h0, RESP_OKAY);
        line_rx_valid <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge sys_clk);
            if (!line_rx_ready) break;
            rx_q.push_back(line_rx_data);
            r = rnd();
            line_rx_data <= r[3:0];
        end
        line_rx_valid <= 1'b0;
        chk(32'(n), 32'(RX_FIFO_DEPTH));
        axi_rd(REG_STATUS, 32'h3c0, 32'(RX_FIFO_DEPTH) << 6, RESP_OKAY);
        // transmit overlaps the drain so the collision output sees both
        tx_go <= 1'b1;
        axi_wr(REG_CONTROL, 32'h1, RESP_OKAY);
        for (n = 0; n < 300 && rx_q.size() > 0; n++) @(posedge sys_clk);
        if (n == 300) hang();
        tx_go <= 1'b0;
        repeat (40) @(posedge sys_clk);
        chk(32'(tx_q.size()), 32'h0);
        $display("receive done");
        r = rnd();
        sv <= r[14:0];
        line_speed_100 <= r[20];
        hw_reset_pin_n <= 1'b0;
        repeat (8) @(posedge sys_clk);
        chk(32'(strap_pin_oe_n), 32'(PINS_RELEASED));
        hw_reset_pin_n <= 1'b1;
        repeat (16) @(posedge sys_clk);
        axi_rd(REG_STRAPS, 32'h7e1f, xs(sv), RESP_OKAY);
        axi_rd(REG_STATUS, 32'h1f, xt(sv), RESP_OKAY);
        old = sv;
        r = rnd();
        sv <= r[14:0];
        repeat (4) @(posedge sys_clk);
        axi_rd(REG_STRAPS, 32'h7e1f, xs(old), RESP_OKAY);
        repeat (4) @(posedge sys_clk);
        $display("hardware reset done");
        report_and_stop();
    end
endmodule : tb
